// ### dv/fdl_line_model.sv
// Purpose: Line side of the framer, giving one link bit slot per call.
// Assumes: One idle cycle separates two slots.
// Notes: The released data line shows the inverse bit, so a late sample fails.
module fdl_line_model (
    input wire logic pclk,
    input wire logic tx_link_bit,
    output logic fdl_strobe,
    output logic fs_strobe,
    output logic rx_link_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sent_bit;
    initial
    begin
        fdl_strobe = 1'b0;
        fs_strobe = 1'b0;
        rx_link_bit = 1'b0;
        sent_bit = 1'b0;
    end
    task automatic bit_slot(input logic b, input logic esf);
        @(posedge pclk);
        fdl_strobe <= esf;
        fs_strobe <= ~esf;
        rx_link_bit <= b;
        @(posedge pclk);
        fdl_strobe <= 1'b0;
        fs_strobe <= 1'b0;
        rx_link_bit <= ~b;
        #1;
        sent_bit = tx_link_bit;
    endtask
endmodule

// ### dv/tb.sv
// Purpose: Self-checking bench for the data link access block.
// Assumes: Zero wait APB slave; registers hold 8 bits in the low byte.
// Notes: Link slots come from the line model; DS0 octets are driven here.
`include "fdl_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rx_block_hit, tx_block_hit, tx_hdlc_link_bit, ext_link_input;
    logic tx_link_bit, int_n, fdl_strobe, fs_strobe, rx_link_bit;
    logic [7:0] tx_hdlc_octet, tx_hdlc_take;
    logic [15:0] v;
    fdl_pkg::fdl_ds0_t rx_ds0, tx_ds0_in, tx_ds0_out;
    fdl_pkg::fdl_hdlc_t rx_hdlc, last_hdlc;
    int err_count, n_compared, hdlc_cnt, c0;
    fdl_link_access dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fdl_strobe(fdl_strobe), .fs_strobe(fs_strobe),
        .rx_link_bit(rx_link_bit), .rx_ds0(rx_ds0), .rx_block_hit(rx_block_hit),
        .rx_hdlc(rx_hdlc), .tx_ds0_in(tx_ds0_in), .tx_block_hit(tx_block_hit),
        .tx_hdlc_octet(tx_hdlc_octet), .tx_hdlc_link_bit(tx_hdlc_link_bit),
        .ext_link_input(ext_link_input), .tx_ds0_out(tx_ds0_out),
        .tx_hdlc_take(tx_hdlc_take), .tx_link_bit(tx_link_bit), .int_n(int_n));
    fdl_line_model line (.pclk(pclk), .tx_link_bit(tx_link_bit), .fdl_strobe(fdl_strobe),
        .fs_strobe(fs_strobe), .rx_link_bit(rx_link_bit));
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (rx_hdlc.valid === 1'b1)
        begin
            hdlc_cnt++;
            last_hdlc = rx_hdlc;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(rd & {24'h000000, m}, {24'h000000, e});
    endtask
    task automatic send(input logic [15:0] b, input int n, input logic esf);
        for (int i = 0; i < n; i++)
            line.bit_slot(b[i], esf);
    endtask
    task automatic collect(input int n);
        v = 16'h0000;
        for (int i = 0; i < n; i++)
        begin
            line.bit_slot(1'b0, 1'b1);
            v[i] = line.sent_bit;
        end
    endtask
    task automatic rxd(input logic [4:0] ch, input logic [7:0] o, input int dn, input int e);
        c0 = hdlc_cnt;
        @(posedge pclk);
        rx_ds0 <= {1'b1, ch, o};
        @(posedge pclk);
        rx_ds0 <= '0;
        @(posedge pclk);
        #1;
        chk(32'(hdlc_cnt - c0), 32'(dn));
        chk(32'(last_hdlc), 32'(e));
    endtask
    task automatic txd(input logic [4:0] ch, input logic [13:0] e, input logic [7:0] tk);
        @(posedge pclk);
        tx_ds0_in <= {1'b1, ch, 8'h3C};
        @(posedge pclk);
        tx_ds0_in <= '0;
        #1;
        chk(32'(tx_ds0_out), 32'(e));
        chk(32'(tx_hdlc_take), 32'(tk));
    endtask
    task automatic stop_test();
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #250000;
        err_count++;
        stop_test();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, rx_block_hit, tx_block_hit} = '0;
        {rx_ds0, tx_ds0_in, tx_hdlc_octet, tx_hdlc_link_bit} = '0;
        ext_link_input = 1'b1;
        {err_count, n_compared, hdlc_cnt} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++)
            rdc(`FDL_IDX_RX_CHAN_CTRL + 10'(i), 8'hFF, 8'h00);
        rdc(`FDL_IDX_RX_MATCH_A, 8'hFF, 8'h00);
        apb(1'b1, `FDL_IDX_RX_CHAN_CTRL, 8'hFF);
        rdc(`FDL_IDX_RX_CHAN_CTRL, 8'hFF, 8'hBF);
        apb(1'b1, `FDL_IDX_RX_LINK_BYTE, 8'hFF);
        rdc(`FDL_IDX_RX_LINK_BYTE, 8'hFF, 8'h00);
        apb(1'b0, 10'h3FF, 8'h00);
        chk({31'h0, slv}, 32'h1);
        apb(1'b1, `FDL_IDX_RX_CHAN_CTRL, 8'h00);
        apb(1'b1, `FDL_IDX_RX_MATCH_A, 8'h1F);
        apb(1'b1, `FDL_IDX_RX_MATCH_B, 8'hA5);
        apb(1'b1, `FDL_IDX_MASK, 8'h03);
        apb(1'b1, `FDL_IDX_STATUS, 8'h07);
        send(16'h00A5, 8, 1'b0);
        rdc(`FDL_IDX_STATUS, 8'h03, 8'h03);
        chk({31'h0, int_n}, 32'h0);
        rdc(`FDL_IDX_RX_LINK_BYTE, 8'hFF, 8'hA5);
        apb(1'b1, `FDL_IDX_STATUS, 8'h07);
        @(posedge pclk);
        #1;
        chk({31'h0, int_n}, 32'h1);
        apb(1'b1, `FDL_IDX_CONTROL, 8'h01);
        send(16'h003F, 8, 1'b0);
        rdc(`FDL_IDX_STATUS, 8'h03, 8'h01);
        rdc(`FDL_IDX_RX_LINK_BYTE, 8'hFF, 8'h3F);
        apb(1'b1, `FDL_IDX_STATUS, 8'h07);
        send(16'h001F, 9, 1'b0);
        rdc(`FDL_IDX_RX_LINK_BYTE, 8'hFF, 8'h1F);
        rdc(`FDL_IDX_STATUS, 8'h03, 8'h03);
        apb(1'b1, `FDL_IDX_CONTROL, 8'h18);
        apb(1'b1, `FDL_IDX_MASK, 8'h04);
        apb(1'b1, `FDL_IDX_TX_LINK_BYTE, 8'h5A);
        apb(1'b1, `FDL_IDX_STATUS, 8'h07);
        for (int i = 0; i < 10 && rd[2] !== 1'b1; i++)
        begin
            line.bit_slot(1'b0, 1'b1);
            apb(1'b0, `FDL_IDX_STATUS, 8'h00);
        end
        chk({31'h0, rd[2]}, 32'h1);
        apb(1'b1, `FDL_IDX_TX_LINK_BYTE, 8'h1F);
        apb(1'b1, `FDL_IDX_CONTROL, 8'h1A);
        apb(1'b1, `FDL_IDX_STATUS, 8'h07);
        collect(8);
        chk(32'(v), 32'h5A);
        rdc(`FDL_IDX_STATUS, 8'h04, 8'h04);
        chk({31'h0, int_n}, 32'h0);
        collect(9);
        chk(32'(v), 32'h01F);
        collect(9);
        chk(32'(v), 32'h01F);
        for (int s = 0; s < 2; s++)
        begin
            apb(1'b1, `FDL_IDX_CONTROL, 8'h10 | 8'(s << 2));
            line.bit_slot(1'b1, 1'b1);
            chk({31'h0, line.sent_bit}, 32'(s == 0));
            // The HDLC copy of the link bit is registered, so let it reach the monitor.
            @(posedge pclk);
            #1;
            chk(32'(last_hdlc), 32'h10101);
        end
        apb(1'b1, `FDL_IDX_RX_CHAN_CTRL, 8'h85);
        apb(1'b1, `FDL_IDX_RX_SUPPRESS, 8'h81);
        rxd(5'd5, 8'h3C, 1, 32'h13C7E);
        rxd(5'd6, 8'h55, 0, 32'h13C7E);
        apb(1'b1, `FDL_IDX_RX_CHAN_CTRL, 8'hA0);
        rx_block_hit <= 1'b1;
        rxd(5'd9, 8'h55, 1, 32'h1557E);
        apb(1'b1, `FDL_IDX_TX_CHAN_CTRL, 8'h03);
        apb(1'b1, `FDL_IDX_TX_SUPPRESS, 8'h0F);
        tx_hdlc_octet <= 8'hA5;
        txd(5'd3, 14'h233C, 8'h00);
        apb(1'b1, `FDL_IDX_TX_CHAN_CTRL, 8'h83);
        txd(5'd3, 14'h23AC, 8'hF0);
        txd(5'd4, 14'h243C, 8'h00);
        apb(1'b1, `FDL_IDX_TX_CHAN_CTRL, 8'hA0);
        tx_block_hit <= 1'b1;
        txd(5'd4, 14'h24AC, 8'hF0);
        stop_test();
    end
endmodule

// ### logic/fdl_defines.svh
`ifndef FDL_DEFINES_SVH
`define FDL_DEFINES_SVH

// Register indices; byte address is four times the index.
`define FDL_IDX_RX_LINK_BYTE 10'h028
`define FDL_IDX_RX_MATCH_A 10'h029
`define FDL_IDX_RX_MATCH_B 10'h02A
`define FDL_IDX_TX_LINK_BYTE 10'h07E
`define FDL_IDX_RX_CHAN_CTRL 10'h090
`define FDL_IDX_RX_SUPPRESS 10'h091
`define FDL_IDX_TX_CHAN_CTRL 10'h092
`define FDL_IDX_TX_SUPPRESS 10'h093
`define FDL_IDX_STATUS 10'h0A0
`define FDL_IDX_MASK 10'h0A1
`define FDL_IDX_CONTROL 10'h0A2

// Channel control fields.
`define FDL_CC_TS_ENABLE 7
`define FDL_CC_SEL_MODE 5
`define FDL_CC_CHAN_MSB 4
`define FDL_CC_WMASK 8'hBF

// Status and mask fields.
`define FDL_ST_RX_FULL 0
`define FDL_ST_RX_MATCH 1
`define FDL_ST_TX_EMPTY 2

// Control fields.
`define FDL_CT_RX_DESTUFF 0
`define FDL_CT_TX_STUFF 1
`define FDL_CT_TX_SOURCE 2
`define FDL_CT_TX_LEGACY 3
`define FDL_CT_ESF_MODE 4

`define FDL_REG_RESET 8'h00
`define FDL_STUFF_RUN 3'h5
`define FDL_ONES_SAT 3'h6
`define FDL_BYTE_LAST 3'h7

`endif

// ### logic/fdl_link_access.sv
// Purpose: Routes the HDLC controllers to the data link or DS0 slots and
//          holds the legacy byte-wide data link receive and transmit paths.
// Assumes: Bit and timeslot strobes are one-cycle pulses synchronous to pclk.
// Notes: APB slave, zero wait states, 8-bit registers in the low data bits.
// How it works
// - rx timeslot enable picks link or DS0
// - rx mode picks single channel or block
// - rx suppress bits drop DS0 bit positions
// - tx timeslot enable picks link or DS0
// - tx mode picks single channel or block
// - tx suppress bits keep payload bit positions
// - receive paths parallel, one transmit source
// - eight link bits fill byte, set full
// - masked full flag drives interrupt low
// - full byte compared with both match registers
// - first received bit lands in LSB
// - destuffer drops zero after five ones
// - zero after six ones is kept
// - transmit byte sent LSB first per mode
// - eight bits sent sets empty flag
// - unrefreshed transmit byte is resent
// - stuffer inserts zero after five ones
// - source select picks pin or controller
`include "fdl_defines.svh"

module fdl_link_access (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fdl_strobe,
    input wire logic fs_strobe,
    input wire logic rx_link_bit,
    input wire fdl_pkg::fdl_ds0_t rx_ds0,
    input wire logic rx_block_hit,
    output fdl_pkg::fdl_hdlc_t rx_hdlc,
    input wire fdl_pkg::fdl_ds0_t tx_ds0_in,
    input wire logic tx_block_hit,
    input wire logic [7:0] tx_hdlc_octet,
    input wire logic tx_hdlc_link_bit,
    input wire logic ext_link_input,
    output fdl_pkg::fdl_ds0_t tx_ds0_out,
    output logic [7:0] tx_hdlc_take,
    output logic tx_link_bit,
    output logic int_n
);

    logic [7:0] rx_link_byte_q;
    logic [7:0] rx_link_match_a_q;
    logic [7:0] rx_link_match_b_q;
    logic [7:0] tx_link_byte_q;
    logic [7:0] rx_hdlc_channel_ctrl_q;
    logic [7:0] rx_hdlc_bit_suppress_q;
    logic [7:0] tx_hdlc_channel_ctrl_q;
    logic [7:0] tx_hdlc_bit_suppress_q;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic [4:0] control_q;
    logic [31:0] prdata_q;
    logic int_n_q;

    logic [7:0] rx_sh_q;
    logic [2:0] rx_cnt_q;
    logic [2:0] rx_ones_q;
    logic [7:0] tx_sh_q;
    logic [2:0] tx_cnt_q;
    logic [2:0] tx_ones_q;
    logic tx_link_bit_q;
    fdl_pkg::fdl_hdlc_t rx_hdlc_q;
    fdl_pkg::fdl_ds0_t tx_ds0_q;
    logic [7:0] tx_take_q;

    logic [9:0] idx;
    logic addr_ok;
    logic setup;
    logic wr_en;
    logic link_strobe;
    logic rx_drop;
    logic [7:0] rx_sh_next;
    logic rx_byte_done;
    logic rx_match_hit;
    logic tx_stuff_now;
    logic tx_byte_done;
    logic tx_bit_sel;
    logic [2:0] set_ev;
    logic [2:0] clr_ev;

    // A channel is in use by HDLC either by its number or by the block registers.
    function automatic logic chan_selected(input logic [7:0] ctrl, input logic [4:0] chan,
                                           input logic blk_hit);
        logic hit;
        hit = ctrl[`FDL_CC_SEL_MODE] ? blk_hit : (ctrl[`FDL_CC_CHAN_MSB:0] == chan);
        return ctrl[`FDL_CC_TS_ENABLE] & hit;
    endfunction

    function automatic logic known_index(input logic [9:0] i);
        case (i)
            `FDL_IDX_RX_LINK_BYTE, `FDL_IDX_RX_MATCH_A, `FDL_IDX_RX_MATCH_B,
            `FDL_IDX_TX_LINK_BYTE, `FDL_IDX_RX_CHAN_CTRL, `FDL_IDX_RX_SUPPRESS,
            `FDL_IDX_TX_CHAN_CTRL, `FDL_IDX_TX_SUPPRESS, `FDL_IDX_STATUS,
            `FDL_IDX_MASK, `FDL_IDX_CONTROL: known_index = 1'b1;
            default: known_index = 1'b0;
        endcase
    endfunction

    assign idx = paddr[11:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && known_index(idx);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = prdata_q;
    assign int_n = int_n_q;
    assign rx_hdlc = rx_hdlc_q;
    assign tx_ds0_out = tx_ds0_q;
    assign tx_hdlc_take = tx_take_q;
    assign tx_link_bit = tx_link_bit_q;

    // Read data is captured in the setup cycle, so a read shows state as of that edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup)
        begin
            prdata_q <= 32'h0000_0000;
            case (idx)
                `FDL_IDX_RX_LINK_BYTE: prdata_q[7:0] <= rx_link_byte_q;
                `FDL_IDX_RX_MATCH_A: prdata_q[7:0] <= rx_link_match_a_q;
                `FDL_IDX_RX_MATCH_B: prdata_q[7:0] <= rx_link_match_b_q;
                `FDL_IDX_TX_LINK_BYTE: prdata_q[7:0] <= tx_link_byte_q;
                `FDL_IDX_RX_CHAN_CTRL: prdata_q[7:0] <= rx_hdlc_channel_ctrl_q;
                `FDL_IDX_RX_SUPPRESS: prdata_q[7:0] <= rx_hdlc_bit_suppress_q;
                `FDL_IDX_TX_CHAN_CTRL: prdata_q[7:0] <= tx_hdlc_channel_ctrl_q;
                `FDL_IDX_TX_SUPPRESS: prdata_q[7:0] <= tx_hdlc_bit_suppress_q;
                `FDL_IDX_STATUS: prdata_q[2:0] <= status_q;
                `FDL_IDX_MASK: prdata_q[2:0] <= mask_q;
                `FDL_IDX_CONTROL: prdata_q[4:0] <= control_q;
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_link_match_a_q <= `FDL_REG_RESET;
            rx_link_match_b_q <= `FDL_REG_RESET;
            tx_link_byte_q <= `FDL_REG_RESET;
            rx_hdlc_channel_ctrl_q <= `FDL_REG_RESET;
            rx_hdlc_bit_suppress_q <= `FDL_REG_RESET;
            tx_hdlc_channel_ctrl_q <= `FDL_REG_RESET;
            tx_hdlc_bit_suppress_q <= `FDL_REG_RESET;
            mask_q <= 3'h0;
            control_q <= 5'h00;
        end
        else if (wr_en)
        begin
            case (idx)
                `FDL_IDX_RX_MATCH_A: rx_link_match_a_q <= pwdata[7:0];
                `FDL_IDX_RX_MATCH_B: rx_link_match_b_q <= pwdata[7:0];
                `FDL_IDX_TX_LINK_BYTE: tx_link_byte_q <= pwdata[7:0];
                `FDL_IDX_RX_CHAN_CTRL: rx_hdlc_channel_ctrl_q <= pwdata[7:0] & `FDL_CC_WMASK;
                `FDL_IDX_RX_SUPPRESS: rx_hdlc_bit_suppress_q <= pwdata[7:0];
                `FDL_IDX_TX_CHAN_CTRL: tx_hdlc_channel_ctrl_q <= pwdata[7:0] & `FDL_CC_WMASK;
                `FDL_IDX_TX_SUPPRESS: tx_hdlc_bit_suppress_q <= pwdata[7:0];
                `FDL_IDX_MASK: mask_q <= pwdata[2:0];
                `FDL_IDX_CONTROL: control_q <= pwdata[4:0];
                default: mask_q <= mask_q;
            endcase
        end
    end

    assign link_strobe = control_q[`FDL_CT_ESF_MODE] ? fdl_strobe : fs_strobe;

    assign rx_drop = control_q[`FDL_CT_RX_DESTUFF] && !rx_link_bit &&
                     (rx_ones_q == `FDL_STUFF_RUN);
    assign rx_sh_next = {rx_link_bit, rx_sh_q[7:1]};
    assign rx_byte_done = link_strobe && !rx_drop && (rx_cnt_q == `FDL_BYTE_LAST);
    assign rx_match_hit = (rx_sh_next == rx_link_match_a_q) ||
                          (rx_sh_next == rx_link_match_b_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_sh_q <= 8'h00;
            rx_cnt_q <= 3'h0;
            rx_ones_q <= 3'h0;
            rx_link_byte_q <= `FDL_REG_RESET;
        end
        else if (link_strobe)
        begin
            if (!rx_link_bit)
                rx_ones_q <= 3'h0;
            else if (rx_ones_q != `FDL_ONES_SAT)
                rx_ones_q <= rx_ones_q + 3'h1;
            if (!rx_drop)
            begin
                rx_sh_q <= rx_sh_next;
                rx_cnt_q <= rx_cnt_q + 3'h1;
                if (rx_byte_done)
                    rx_link_byte_q <= rx_sh_next;
            end
        end
    end

    assign tx_stuff_now = control_q[`FDL_CT_TX_STUFF] && (tx_ones_q == `FDL_STUFF_RUN);
    assign tx_byte_done = link_strobe && control_q[`FDL_CT_TX_LEGACY] && !tx_stuff_now &&
                          (tx_cnt_q == `FDL_BYTE_LAST);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_sh_q <= 8'h00;
            tx_cnt_q <= 3'h0;
            tx_ones_q <= 3'h0;
        end
        else if (link_strobe && control_q[`FDL_CT_TX_LEGACY])
        begin
            if (tx_stuff_now)
                tx_ones_q <= 3'h0;
            else
            begin
                tx_ones_q <= tx_sh_q[0] ? tx_ones_q + 3'h1 : 3'h0;
                tx_cnt_q <= tx_cnt_q + 3'h1;
                tx_sh_q <= tx_byte_done ? tx_link_byte_q : {1'b0, tx_sh_q[7:1]};
            end
        end
    end

    always_comb
    begin
        if (control_q[`FDL_CT_TX_LEGACY])
            tx_bit_sel = tx_stuff_now ? 1'b0 : tx_sh_q[0];
        else if (!control_q[`FDL_CT_TX_SOURCE])
            tx_bit_sel = ext_link_input;
        else if (tx_hdlc_channel_ctrl_q[`FDL_CC_TS_ENABLE])
            tx_bit_sel = 1'b1;
        else
            tx_bit_sel = tx_hdlc_link_bit;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_link_bit_q <= 1'b1;
        else if (link_strobe)
            tx_link_bit_q <= tx_bit_sel;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_hdlc_q <= '0;
        else if (!rx_hdlc_channel_ctrl_q[`FDL_CC_TS_ENABLE])
        begin
            rx_hdlc_q.valid <= link_strobe;
            rx_hdlc_q.data <= {7'h00, rx_link_bit};
            rx_hdlc_q.use_mask <= 8'h01;
        end
        else
        begin
            rx_hdlc_q.valid <= rx_ds0.valid &&
                               chan_selected(rx_hdlc_channel_ctrl_q, rx_ds0.chan, rx_block_hit);
            rx_hdlc_q.data <= rx_ds0.octet;
            rx_hdlc_q.use_mask <= ~rx_hdlc_bit_suppress_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_ds0_q <= '0;
            tx_take_q <= 8'h00;
        end
        else
        begin
            tx_ds0_q <= tx_ds0_in;
            tx_take_q <= 8'h00;
            if (tx_ds0_in.valid &&
                chan_selected(tx_hdlc_channel_ctrl_q, tx_ds0_in.chan, tx_block_hit))
            begin
                tx_ds0_q.octet <= (tx_ds0_in.octet & tx_hdlc_bit_suppress_q) |
                                  (tx_hdlc_octet & ~tx_hdlc_bit_suppress_q);
                tx_take_q <= ~tx_hdlc_bit_suppress_q;
            end
        end
    end

    assign set_ev = {tx_byte_done, rx_byte_done && rx_match_hit, rx_byte_done};
    assign clr_ev = (wr_en && idx == `FDL_IDX_STATUS) ? pwdata[2:0] : 3'h0;

    // A new event in the clearing cycle survives the write-one-to-clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_q <= 3'h0;
        else
            status_q <= set_ev | (status_q & ~clr_ev);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_n_q <= 1'b1;
        else
            int_n_q <= ~|(status_q & mask_q);
    end

    a_full_on_byte: assert property (@(posedge pclk) disable iff (!presetn)
        rx_byte_done |=> status_q[`FDL_ST_RX_FULL] && rx_link_byte_q == $past(rx_sh_next))
        else $error("full flag or byte missing after eighth bit");
    a_lsb_first: assert property (@(posedge pclk) disable iff (!presetn)
        link_strobe && !rx_drop |=> rx_sh_q[7] == $past(rx_link_bit))
        else $error("received bit not shifted in at the top");
    a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rx_byte_done && (rx_sh_next == rx_link_match_b_q) |=> status_q[`FDL_ST_RX_MATCH])
        else $error("match flag not set on equal byte");
    a_destuff_drop: assert property (@(posedge pclk) disable iff (!presetn)
        link_strobe && rx_drop |=> $stable(rx_sh_q) && $stable(rx_cnt_q))
        else $error("stuffed zero was not discarded");
    a_six_ones_kept: assert property (@(posedge pclk) disable iff (!presetn)
        link_strobe && !rx_link_bit && rx_ones_q == `FDL_ONES_SAT |=> !rx_sh_q[7])
        else $error("zero after six ones was dropped");
    a_stuff_zero: assert property (@(posedge pclk) disable iff (!presetn)
        link_strobe && control_q[`FDL_CT_TX_LEGACY] && tx_stuff_now |=> !tx_link_bit_q)
        else $error("no zero inserted after five ones");
    a_resend_byte: assert property (@(posedge pclk) disable iff (!presetn)
        tx_byte_done |=> tx_sh_q == $past(tx_link_byte_q) && status_q[`FDL_ST_TX_EMPTY])
        else $error("transmit byte not reloaded or empty flag missing");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        status_q[`FDL_ST_RX_FULL] && mask_q[`FDL_ST_RX_FULL] |=> !int_n_q)
        else $error("interrupt not asserted for masked-in full flag");
    a_ext_source: assert property (@(posedge pclk) disable iff (!presetn)
        link_strobe && control_q[3:2] == 2'h0 |=> tx_link_bit_q == $past(ext_link_input))
        else $error("pin source not passed to the link");
    a_rx_suppress: assert property (@(posedge pclk) disable iff (!presetn)
        rx_hdlc_channel_ctrl_q[`FDL_CC_TS_ENABLE]
        |=> rx_hdlc_q.use_mask == ~$past(rx_hdlc_bit_suppress_q))
        else $error("receive suppress mask not applied");

endmodule

// ### logic/fdl_pkg.sv
// Purpose: Types shared by the facility data link access logic.
// Assumes: Octets arrive one per DS0 timeslot with their channel number.
// Notes: Constants live in fdl_defines.svh.
package fdl_pkg;
    typedef struct packed {
        logic valid;
        logic [4:0] chan;
        logic [7:0] octet;
    } fdl_ds0_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic [7:0] use_mask;
    } fdl_hdlc_t;
endpackage
